/* File: pcr_defs.svh */
// Purpose: constants of the power, clock and reset control block
// Assumes: APB register bus, core clock of 200 MHz
// Notes:   offsets are byte addresses inside a 4 KB window
// Function
// RULE1: three power modes, hardware runs every transition
// RULE2: active mode forces no clock gating
// RULE3: sleep gates processor subsystem clock only
// RULE4: sleep wake restores processor clock immediately
// RULE5: deep sleep stops fast clock, 35 us wake
// RULE6: wake unit wakes on enabled interrupts
// RULE7: no mode entry without supply; brownout resets
// RULE8: glitch-free source switch, synchronised inputs
// RULE9: four selectable clock sources
// RULE10: main oscillator 24 MHz, 24-48 in 4 MHz
// RULE11: main oscillator trimmed against crystal
// RULE12: 40 kHz oscillator clocks watchdog, deep sleep
// RULE13: eight 16-bit dividers, two fractional
// RULE14: dividers, prescaler derived from fast clock
// RULE15: watchdog runs in deep sleep, resets on timeout
// RULE16: watchdog reset flagged in reset cause
// RULE17: reset cause survives the reset it records
// RULE18: several reset sources incl. software
// RULE19: reset asserts asynchronously to known state
// RULE20: outside party drives reset pin low
// RULE21: service restarts watchdog count
`ifndef PCR_DEFS_SVH
`define PCR_DEFS_SVH

`define PCR_CLK_NS       5
`define PCR_WAKE_NS      35000
`define PCR_WAKE_CYC     ((`PCR_WAKE_NS + `PCR_CLK_NS - 1) / `PCR_CLK_NS)
`define PCR_RST_HOLD     8'h10

`define A_PWR_CTRL       12'h000
`define A_WAKE_MASK      12'h004
`define A_CLK_CTRL       12'h008
`define A_PRESCALE       12'h00C
`define A_DOG_CTRL       12'h010
`define A_DOG_SERVICE    12'h014
`define A_RESET_CAUSE    12'h018
`define A_SW_RESET       12'h01C
`define A_STATUS         12'h020
`define A_DOG_COUNT      12'h024
`define A_DIV_BASE       12'h040
`define PCR_DIV_MASK     12'hFE0

`define F_DEEP           0
`define F_SRC            0
`define F_CODE           4
`define F_TRIM_EN        8
`define F_DOG_EN         16
`define F_ST_SRC         2
`define F_ST_SWITCH      4
`define F_ST_SUPPLY      5
`define F_ST_TRIM        8
`define F_FRAC           16

`define PCR_DOG_KEY      32'h00005A5A
`define PCR_SW_KEY       32'h0000A5A5
`define PCR_DOG_MATCH    16'hFFFF

`define PCR_SRC_MAIN     2'h0
`define PCR_SRC_LOW      2'h1
`define PCR_SRC_XTAL     2'h2
`define PCR_SRC_EXT      2'h3

`define PCR_MOSC_BASE_HZ 24000000
`define PCR_MOSC_STEP_HZ 4000000
`define PCR_XTAL_HZ      32768
`define PCR_CODE_RST     3'h0
`define PCR_CODE_MAX     3'h6
`define PCR_TRIM_RST     8'h80
`define PCR_TRIM_MAX     8'hFF
`define PCR_NUM_DIV      8
`define PCR_NUM_FRAC     2

`endif

/* File: pcr_pkg.sv */
// Purpose: types of the power, clock and reset control block
// Assumes: constants live in pcr_defs.svh
// Notes:   whole block state is one packed struct
package pcr_pkg;

  typedef enum logic [1:0] {st_active, st_sleep, st_deep, st_waking} power_state_e;
  typedef enum logic [1:0] {sw_idle, sw_drop, sw_take} switch_phase_e;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } apb_rsp_s;

  typedef struct packed {
    logic main_internal_oscillator;
    logic low_freq_internal_osc;
    logic crystal_osc_32k;
    logic ext_clk;
  } osc_ticks_s;

  typedef struct packed {
    power_state_e    pwr;
    logic [15:0]     wake_cnt;
    logic            deep_en;
    logic [7:0]      wake_mask;
    logic [1:0]      src_req;
    logic [1:0]      src_act;
    switch_phase_e   sw;
    logic [2:0]      freq_code;
    logic            trim_en;
    logic [7:0]      trim;
    logic [15:0]     trim_cnt;
    logic [7:0]      prescale;
    logic [7:0]      pre_cnt;
    logic [7:0][15:0] div_int;
    logic [7:0][15:0] div_cnt;
    logic [1:0][4:0] div_frac;
    logic [1:0][4:0] div_acc;
    logic [7:0]      div_xtra;
    logic [7:0]      div_pulse;
    logic            hf_en;
    logic            cpu_en;
    logic            lf_en;
    logic            dog_on;
    logic [15:0]     dog_match;
    logic [15:0]     dog_cnt;
    logic [3:0]      cause;
    logic [7:0]      hold;
    logic [7:0]      irq_m;
    logic [7:0]      irq_s;
    logic            pin_m;
    logic            pin_s;
    logic            bo_m;
    logic            bo_s;
    logic [31:0]     prdata;
    logic            perr;
  } pcr_state_s;

endpackage : pcr_pkg

/* File: power_clock_reset_control.sv */
// Purpose: power modes, clock sources, dividers, watchdog and resets
// Assumes: oscillator inputs are one-cycle ticks synchronous to core_clk
// Notes:   clock outputs are enables; cause bits survive internal resets
`timescale 1ns/10ps
`include "pcr_defs.svh"

module power_clock_reset_control #(
  parameter int WAKE_CYCLES = `PCR_WAKE_CYC
) (
  // clock and power-on reset
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  // reset pin, low resets the system
  input  wire logic                external_reset_pin_n,
  // register bus
  input  wire pcr_pkg::apb_req_s   apb_req,
  output pcr_pkg::apb_rsp_s        apb_rsp,
  // supply monitor
  input  wire logic                supply_ok,
  input  wire logic                brownout,
  // oscillator ticks
  input  wire pcr_pkg::osc_ticks_s osc,
  // processor side
  input  wire logic                cpu_sleep_req,
  input  wire logic [7:0]          irq,
  // clock enables
  output logic                     high_freq_clock_en,
  output logic                     processor_clock_en,
  output logic                     low_freq_clock_en,
  output logic [7:0]               periph_clk_en,
  // oscillator control and status
  output logic                     hf_osc_run,
  output logic [2:0]               main_osc_freq_code,
  output logic [7:0]               main_osc_trim,
  output logic [1:0]               power_mode,
  output logic [1:0]               active_src,
  // system reset
  output logic                     sys_rst_n
);
  import pcr_pkg::*;

  pcr_state_s s;
  pcr_state_s next_s;

  function automatic pcr_state_s defaults(input logic [3:0] cause);
    pcr_state_s d;
    d           = '0;
    d.pwr       = st_active;
    d.sw        = sw_idle;
    d.src_req   = `PCR_SRC_MAIN;
    d.src_act   = `PCR_SRC_MAIN;
    d.freq_code = `PCR_CODE_RST;
    d.trim      = `PCR_TRIM_RST;
    d.dog_match = `PCR_DOG_MATCH;
    d.cause     = cause;
    d.hold      = `PCR_RST_HOLD;
    d.pin_m     = 1'b1;
    d.pin_s     = 1'b1;
    return d;
  endfunction : defaults

  function automatic logic tick_of(input logic [1:0] src, input osc_ticks_s t);
    logic r;
    r = 1'b0;
    if (src == `PCR_SRC_MAIN) begin
      r = t.main_internal_oscillator;
    end else if (src == `PCR_SRC_LOW) begin
      r = t.low_freq_internal_osc;
    end else if (src == `PCR_SRC_XTAL) begin
      r = t.crystal_osc_32k;
    end else begin
      r = t.ext_clk;
    end
    return r;
  endfunction : tick_of

  // main oscillator ticks expected per crystal tick
  function automatic logic [15:0] trim_target(input logic [2:0] code);
    int hz;
    hz = `PCR_MOSC_BASE_HZ + int'(code) * `PCR_MOSC_STEP_HZ;
    return 16'(hz / `PCR_XTAL_HZ);
  endfunction : trim_target

  function automatic logic [2:0] sat_code(input logic [2:0] c);
    return (c > `PCR_CODE_MAX) ? `PCR_CODE_MAX : c;
  endfunction : sat_code

  function automatic logic div_end(input logic [15:0] cnt, input logic [15:0] lim,
                                   input logic xtra);
    return {1'b0, cnt} >= ({1'b0, lim} + {16'h0000, xtra});
  endfunction : div_end

  // {hit, data}
  function automatic logic [32:0] read_word(input pcr_state_s st, input logic [11:0] a);
    logic [32:0] r;
    r = {1'b1, 32'h00000000};
    if (a == `A_PWR_CTRL) begin
      r[`F_DEEP] = st.deep_en;
    end else if (a == `A_WAKE_MASK) begin
      r[7:0] = st.wake_mask;
    end else if (a == `A_CLK_CTRL) begin
      r[`F_SRC +: 2]  = st.src_req;
      r[`F_CODE +: 3] = st.freq_code;
      r[`F_TRIM_EN]   = st.trim_en;
    end else if (a == `A_PRESCALE) begin
      r[7:0] = st.prescale;
    end else if (a == `A_DOG_CTRL) begin
      r[15:0]      = st.dog_match;
      r[`F_DOG_EN] = st.dog_on;
    end else if (a == `A_DOG_SERVICE || a == `A_SW_RESET) begin
      r[31:0] = 32'h00000000;
    end else if (a == `A_RESET_CAUSE) begin
      r[3:0] = st.cause;
    end else if (a == `A_STATUS) begin
      r[1:0]             = st.pwr;
      r[`F_ST_SRC +: 2]  = st.src_act;
      r[`F_ST_SWITCH]    = (st.sw != sw_idle);
      r[`F_ST_SUPPLY]    = (st.hold == 8'h00);
      r[`F_ST_TRIM +: 8] = st.trim;
    end else if (a == `A_DOG_COUNT) begin
      r[15:0] = st.dog_cnt;
    end else if ((a & `PCR_DIV_MASK) == `A_DIV_BASE) begin
      r[15:0] = st.div_int[a[4:2]];
      if (a[4:3] == 2'h0) begin
        r[`F_FRAC +: 5] = st.div_frac[a[2]];
      end
    end else begin
      r = 33'h000000000;
    end
    return r;
  endfunction : read_word

  always_comb begin
    logic        src_tick;
    logic        hf;
    logic        pre_hit;
    logic [7:0]  ends;
    logic [15:0] tgt;
    logic        dog_fire;
    logic        sw_rst;
    logic        wake;
    logic [3:0]  ev;
    logic [32:0] rd;
    logic        setup;
    logic        wr;
    logic [11:0] a;
    logic [31:0] wd;
    src_tick = 1'b0;
    hf       = 1'b0;
    pre_hit  = 1'b0;
    ends     = 8'h00;
    tgt      = 16'h0000;
    dog_fire = 1'b0;
    sw_rst   = 1'b0;
    wake     = 1'b0;
    ev       = 4'h0;
    rd       = 33'h000000000;
    a        = apb_req.paddr;
    wd       = apb_req.pwdata;
    setup    = apb_req.psel && !apb_req.penable;
    wr       = apb_req.psel && apb_req.penable && apb_req.pwrite;
    next_s   = s;

    // two-stage synchronisers on the asynchronous inputs
    next_s.irq_m = irq;                                  // [RULE8]
    next_s.irq_s = s.irq_m;
    next_s.pin_m = external_reset_pin_n;
    next_s.pin_s = s.pin_m;
    next_s.bo_m  = brownout;
    next_s.bo_s  = s.bo_m;

    // fast clock runs only outside deep sleep and the wake delay
    src_tick = tick_of(s.src_act, osc);                  // [RULE9]
    hf = (s.pwr == st_active || s.pwr == st_sleep)       // [RULE5]
         && (s.sw == sw_idle) && src_tick;

    // glitch-free switch: finish an old tick, then start on a new one
    case (s.sw)                                          // [RULE8]
      sw_idle: begin
        if (s.src_req != s.src_act) begin
          next_s.sw = sw_drop;
        end
      end
      sw_drop: begin
        if (src_tick) begin
          next_s.sw = sw_take;
        end
      end
      sw_take: begin
        if (tick_of(s.src_req, osc)) begin
          next_s.src_act = s.src_req;
          next_s.sw      = sw_idle;
        end
      end
      default: begin
        next_s.sw = sw_idle;
      end
    endcase

    // processor prescaler on the fast clock
    if (hf) begin                                        // [RULE14]
      if (s.pre_cnt == s.prescale) begin
        next_s.pre_cnt = 8'h00;
        pre_hit        = 1'b1;
      end else begin
        next_s.pre_cnt = s.pre_cnt + 8'h01;
      end
    end

    // integer part of every divider
    next_s.div_pulse = 8'h00;
    for (int i = 0; i < `PCR_NUM_DIV; i++) begin         // [RULE13]
      if (hf) begin
        if (div_end(s.div_cnt[i], s.div_int[i], s.div_xtra[i])) begin
          ends[i]             = 1'b1;
          next_s.div_cnt[i]   = 16'h0000;
          next_s.div_pulse[i] = 1'b1;                    // [RULE14]
          next_s.div_xtra[i]  = 1'b0;
        end else begin
          next_s.div_cnt[i] = s.div_cnt[i] + 16'h0001;
        end
      end
    end

    // fractional part: carry of the accumulator stretches the next period
    for (int j = 0; j < `PCR_NUM_FRAC; j++) begin        // [RULE13]
      if (ends[j]) begin
        {next_s.div_xtra[j], next_s.div_acc[j]} =
          {1'b0, s.div_acc[j]} + {1'b0, s.div_frac[j]};
      end
    end

    // trim loop counts oscillator ticks per crystal tick
    if (s.trim_en) begin                                 // [RULE11]
      if (osc.crystal_osc_32k) begin
        tgt = trim_target(s.freq_code);
        if (s.trim_cnt < tgt && s.trim != `PCR_TRIM_MAX) begin
          next_s.trim = s.trim + 8'h01;
        end else if (s.trim_cnt > tgt && s.trim != 8'h00) begin
          next_s.trim = s.trim - 8'h01;
        end
        next_s.trim_cnt = {15'h0000, osc.main_internal_oscillator};
      end else if (osc.main_internal_oscillator && s.trim_cnt != 16'hFFFF) begin
        next_s.trim_cnt = s.trim_cnt + 16'h0001;
      end
    end else begin
      next_s.trim_cnt = 16'h0000;
    end

    // watchdog counts slow ticks in every power mode
    if (s.dog_on && osc.low_freq_internal_osc) begin     // [RULE12]
      if (s.dog_cnt == s.dog_match) begin
        dog_fire = 1'b1;                                 // [RULE15]
      end else begin
        next_s.dog_cnt = s.dog_cnt + 16'h0001;
      end
    end

    // power mode sequencing
    wake = |(s.irq_s & s.wake_mask);                     // [RULE6]
    case (s.pwr)                                         // [RULE1]
      st_active: begin
        if (cpu_sleep_req && supply_ok && s.hold == 8'h00) begin  // [RULE7]
          next_s.pwr = s.deep_en ? st_deep : st_sleep;
        end
      end
      st_sleep: begin
        if (wake) begin
          next_s.pwr = st_active;                        // [RULE4]
        end
      end
      st_deep: begin
        if (wake) begin
          next_s.pwr      = st_waking;
          next_s.wake_cnt = 16'h0000;
        end
      end
      st_waking: begin
        if (s.wake_cnt == 16'(WAKE_CYCLES - 1)) begin    // [RULE5]
          next_s.pwr = st_active;
        end else begin
          next_s.wake_cnt = s.wake_cnt + 16'h0001;
        end
      end
      default: begin
        next_s.pwr = st_active;
      end
    endcase

    // processor clock stops in any low-power mode and during a source switch
    next_s.cpu_en = pre_hit && (next_s.pwr == st_active);  // [RULE2] [RULE3]
    next_s.hf_en  = hf;
    next_s.lf_en  = osc.low_freq_internal_osc;

    // register bus: read data captured in the setup cycle
    if (setup) begin
      rd            = read_word(s, a);
      next_s.prdata = rd[31:0];
      next_s.perr   = !rd[32];
    end
    if (wr) begin
      if (a == `A_PWR_CTRL) begin
        next_s.deep_en = wd[`F_DEEP];
      end else if (a == `A_WAKE_MASK) begin
        next_s.wake_mask = wd[7:0];
      end else if (a == `A_CLK_CTRL) begin
        next_s.src_req   = wd[`F_SRC +: 2];
        next_s.freq_code = sat_code(wd[`F_CODE +: 3]);   // [RULE10]
        next_s.trim_en   = wd[`F_TRIM_EN];
      end else if (a == `A_PRESCALE) begin
        next_s.prescale = wd[7:0];
      end else if (a == `A_DOG_CTRL) begin
        next_s.dog_match = wd[15:0];
        next_s.dog_on    = wd[`F_DOG_EN];
      end else if (a == `A_DOG_SERVICE) begin
        if (wd == `PCR_DOG_KEY) begin
          next_s.dog_cnt = 16'h0000;                     // [RULE21]
          dog_fire       = 1'b0;
        end
      end else if (a == `A_RESET_CAUSE) begin
        next_s.cause = s.cause & ~wd[3:0];
      end else if (a == `A_SW_RESET) begin
        sw_rst = (wd == `PCR_SW_KEY);                    // [RULE18]
      end else if ((a & `PCR_DIV_MASK) == `A_DIV_BASE) begin
        next_s.div_int[a[4:2]] = wd[15:0];
        if (a[4:3] == 2'h0) begin
          next_s.div_frac[a[2]] = wd[`F_FRAC +: 5];
        end
      end
    end

    // reset sources; a new cause wins over a clear in the same cycle
    ev = {!s.pin_s, s.bo_s, sw_rst, dog_fire};           // [RULE18] [RULE20]
    if (ev != 4'h0) begin
      next_s = defaults(next_s.cause | ev);              // [RULE16] [RULE17] [RULE7]
    end else if (s.hold != 8'h00 && supply_ok) begin
      next_s.hold = s.hold - 8'h01;                      // [RULE7]
    end
  end

  // of the resets, only power-on reset clears the cause record
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      s <= defaults(4'h0);                               // [RULE19]
    end else begin
      s <= next_s;
    end
  end

  // pin reaches the system reset without waiting for a clock edge
  assign sys_rst_n          = (s.hold == 8'h00) && external_reset_pin_n;  // [RULE19] [RULE20]
  assign apb_rsp.prdata     = s.prdata;
  assign apb_rsp.pready     = 1'b1;
  assign apb_rsp.pslverr    = s.perr && apb_req.psel && apb_req.penable;
  assign high_freq_clock_en = s.hf_en;
  assign processor_clock_en = s.cpu_en;
  assign low_freq_clock_en  = s.lf_en;                   // [RULE12]
  assign periph_clk_en      = s.div_pulse;
  assign hf_osc_run         = (s.pwr == st_active) || (s.pwr == st_sleep);  // [RULE5]
  assign main_osc_freq_code = s.freq_code;               // [RULE10]
  assign main_osc_trim      = s.trim;
  assign power_mode         = s.pwr;
  assign active_src         = s.src_act;

endmodule : power_clock_reset_control

/* File: pcr_checker_asserts.sv */
// Purpose: port checks for power_clock_reset_control
// Assumes: one clock domain, rst_n asynchronous
// Notes:   internal resets are excluded where they re-default the mode
`timescale 1ns/10ps
module pcr_checker #(
  parameter int WAKE_CYCLES = 20
) (
  // clock and resets
  input wire logic                core_clk,
  input wire logic                rst_n,
  input wire logic                external_reset_pin_n,
  // supply and ticks
  input wire logic                supply_ok,
  input wire logic                brownout,
  input wire pcr_pkg::osc_ticks_s osc,
  // observed outputs
  input wire logic                high_freq_clock_en,
  input wire logic                processor_clock_en,
  input wire logic                low_freq_clock_en,
  input wire logic                hf_osc_run,
  input wire logic [2:0]          main_osc_freq_code,
  input wire logic [1:0]          power_mode,
  input wire logic                sys_rst_n
);
  import pcr_pkg::*;
  logic [15:0] wake_len;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // counter, since the wake time exceeds a repetition count
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wake_len <= 16'h0000;
    end else begin
      wake_len <= (power_mode == 2'h3) ? wake_len + 16'h0001 : 16'h0000;
    end
  end
  a_sleep_cpu_off: assert property (
    power_mode == 2'h1 && $past(power_mode) == 2'h1 |-> !processor_clock_en)
    else $error("processor clock ran in sleep");
  a_deep_fast_off: assert property (
    power_mode == 2'h2 && $past(power_mode) == 2'h2 |-> !hf_osc_run && !high_freq_clock_en)
    else $error("fast clock ran in deep sleep");
  a_wake_length: assert property (
    $past(power_mode) == 2'h3 && power_mode == 2'h0 && sys_rst_n |-> int'(wake_len) == WAKE_CYCLES)
    else $error("wake time from deep sleep wrong");
  a_sleep_wake_to: assert property (
    (power_mode == 2'h1) ##1 (power_mode != 2'h1 && sys_rst_n) |-> power_mode == 2'h0)
    else $error("sleep left to a mode other than active");
  a_deep_to_wake: assert property (
    (power_mode == 2'h2) ##1 (power_mode != 2'h2 && sys_rst_n) |-> power_mode == 2'h3)
    else $error("deep sleep left without waking phase");
  a_pin_forces_rst: assert property (
    !external_reset_pin_n |-> !sys_rst_n)
    else $error("reset pin low without system reset");
  a_brown_resets: assert property (
    brownout [*3] |-> ##[0:3] !sys_rst_n)
    else $error("brownout gave no reset");
  a_unsupplied_stay: assert property (
    power_mode == 2'h0 && !supply_ok |=> power_mode == 2'h0)
    else $error("mode entered without valid supply");
  a_code_in_range: assert property (
    main_osc_freq_code <= 3'h6)
    else $error("oscillator code above top step");
  a_low_clk_copy: assert property (
    sys_rst_n && $past(sys_rst_n) |-> low_freq_clock_en == $past(osc.low_freq_internal_osc))
    else $error("low clock enable lost a tick");
  c_sleep: cover property (power_mode == 2'h1);
  c_waking: cover property ($past(power_mode) == 2'h3 && power_mode == 2'h0);
  c_int_reset: cover property ($fell(sys_rst_n));
endmodule : pcr_checker

bind power_clock_reset_control pcr_checker #(.WAKE_CYCLES(WAKE_CYCLES)) chk_u (
  .core_clk(core_clk), .rst_n(rst_n), .external_reset_pin_n(external_reset_pin_n),
  .supply_ok(supply_ok), .brownout(brownout), .osc(osc),
  .high_freq_clock_en(high_freq_clock_en), .processor_clock_en(processor_clock_en),
  .low_freq_clock_en(low_freq_clock_en), .hf_osc_run(hf_osc_run),
  .main_osc_freq_code(main_osc_freq_code), .power_mode(power_mode), .sys_rst_n(sys_rst_n));

/* File: pcr_cpu_model.sv */
// Purpose: processor side partner driving sleep, interrupts and reset pin
// Assumes: commands change by non-blocking assignment at clock edges
// Notes:   pin idles high as its pull-up would hold it
`timescale 1ns/10ps
module pcr_cpu_model (
  // commands from the bench
  input  wire logic       cmd_sleep,
  input  wire logic [7:0] cmd_irq,
  input  wire logic       cmd_pin,
  // device status
  input  wire logic [1:0] power_mode,
  // to the device
  output logic            cpu_sleep_req,
  output logic [7:0]      irq,
  output logic            external_reset_pin_n
);
  // a core asleep cannot ask again
  assign cpu_sleep_req        = cmd_sleep && (power_mode == 2'h0);
  assign irq                  = cmd_irq;
  assign external_reset_pin_n = !cmd_pin;
endmodule : pcr_cpu_model

/* File: tb_top.sv */
// Purpose: self-checking bench for power_clock_reset_control
// Assumes: random oscillator ticks, fixed seed
// Notes:   wake time shortened to 20 cycles
`timescale 1ns/10ps
`include "pcr_defs.svh"
`define CHK(g, x) begin compares++; if ((g) !== (x)) begin miscompares++; $display("unexpected at %0t: got %0h expected %0h", $time, (g), (x)); end end
`define WAIT(c) begin for (wc = 0; wc < 5000 && !(c); wc++) begin @(posedge core_clk); #1; end if (!(c)) begin miscompares++; report_and_stop(); end end
module tb_top;
  import pcr_pkg::*;
  localparam int WAKE = 20;
  logic       core_clk = 1'b0;
  logic       rst_n, supply_ok, brownout, cmd_sleep, cmd_pin, meas, e;
  logic       cpu_sleep_req, external_reset_pin_n, high_freq_clock_en, processor_clock_en;
  logic       low_freq_clock_en, hf_osc_run, sys_rst_n;
  logic [7:0] cmd_irq, irq, periph_clk_en, main_osc_trim;
  logic [2:0] main_osc_freq_code;
  logic [1:0] power_mode, active_src;
  logic [31:0] q;
  apb_req_s   apb_req;
  apb_rsp_s   apb_rsp;
  osc_ticks_s osc;
  int         miscompares, compares, wc, n, m, p, k, hc, dc, fc, cc;

  power_clock_reset_control #(.WAKE_CYCLES(WAKE)) dut_u (
    .core_clk(core_clk), .rst_n(rst_n), .external_reset_pin_n(external_reset_pin_n),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .supply_ok(supply_ok), .brownout(brownout),
    .osc(osc), .cpu_sleep_req(cpu_sleep_req), .irq(irq),
    .high_freq_clock_en(high_freq_clock_en), .processor_clock_en(processor_clock_en),
    .low_freq_clock_en(low_freq_clock_en), .periph_clk_en(periph_clk_en),
    .hf_osc_run(hf_osc_run), .main_osc_freq_code(main_osc_freq_code),
    .main_osc_trim(main_osc_trim), .power_mode(power_mode), .active_src(active_src),
    .sys_rst_n(sys_rst_n));
  pcr_cpu_model cpu_u (
    .cmd_sleep(cmd_sleep), .cmd_irq(cmd_irq), .cmd_pin(cmd_pin), .power_mode(power_mode),
    .cpu_sleep_req(cpu_sleep_req), .irq(irq), .external_reset_pin_n(external_reset_pin_n));

  always #2.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    osc.main_internal_oscillator <= ($urandom_range(1, 0) == 0);
    osc.low_freq_internal_osc    <= ($urandom_range(8, 0) == 0);
    osc.crystal_osc_32k          <= ($urandom_range(12, 0) == 0);
    osc.ext_clk                  <= ($urandom_range(2, 0) == 0);
    if (meas) begin
      hc += int'(high_freq_clock_en);
      dc += int'(periph_clk_en[2]);
      fc += int'(periph_clk_en[0]);
      cc += int'(processor_clock_en);
    end
  end

  function automatic logic [2:0] exp_code(input int c);
    return (c > 6) ? 3'h6 : 3'(c);
  endfunction : exp_code
  // pulse count d against h fast ticks, period m32/32 ticks, one period plus one tick of slack
  function automatic logic near(input int h, input int d, input int m32);
    int x;
    x = h * 32 - d * m32;
    return (x <= m32 + 32) && (x >= -m32 - 32);
  endfunction : near

  task automatic report_and_stop();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : report_and_stop

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    @(posedge core_clk);
    apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge core_clk);
    apb_req.penable <= 1'b1;
    for (t = 0; t < 50; t++) begin
      @(posedge core_clk);
      if (apb_rsp.pready === 1'b1) break;
    end
    if (t == 50) begin
      miscompares++;
      report_and_stop();
    end
    q = apb_rsp.prdata;
    e = apb_rsp.pslverr;
    apb_req <= '0;
    #1;
  endtask : apb

  task automatic trigger(input int r);
    case (r)
      0: begin
        apb(1'b1, `A_DOG_CTRL, 32'h00010007);
        // frequent service keeps the count far below the match
        repeat (30) begin
          apb(1'b1, `A_DOG_SERVICE, `PCR_DOG_KEY);
          `CHK(sys_rst_n, 1'b1)
        end
      end
      1: begin
        apb(1'b1, `A_SW_RESET, 32'h00001234);
        repeat (4) @(posedge core_clk);
        #1 `CHK(sys_rst_n, 1'b1)
        apb(1'b1, `A_SW_RESET, `PCR_SW_KEY);
      end
      2: begin
        @(posedge core_clk) brownout <= 1'b1;
        repeat (6) @(posedge core_clk);
        brownout <= 1'b0;
        #1 `CHK(sys_rst_n, 1'b0)
      end
      default: begin
        @(posedge core_clk) cmd_pin <= 1'b1;
        #1 `CHK(sys_rst_n, 1'b0)
        repeat (3) @(posedge core_clk);
        cmd_pin <= 1'b0;
      end
    endcase
  endtask : trigger

  initial begin
    void'($urandom(32'h85FA90CE));
    {rst_n, brownout, cmd_sleep, cmd_pin, meas} = '0;
    {supply_ok, cmd_irq, apb_req} = {1'b1, 8'h00, 47'h0};
    repeat (20) @(posedge core_clk);
    `CHK({sys_rst_n, power_mode, main_osc_trim, main_osc_freq_code}, 14'h0400)
    rst_n <= 1'b1;
    for (n = 0; sys_rst_n !== 1'b1 && n < 100; n++) begin @(posedge core_clk); #1; end
    `CHK(n, 16)
    apb(1'b0, 12'h800, 32'h0);
    `CHK({q, e}, {32'h0, 1'b1})
    apb(1'b0, `A_DOG_CTRL, 32'h0);
    `CHK(q, 32'h0000FFFF)
    $display("end of test reset and registers");
    for (int c = 0; c < 8; c++) begin
      apb(1'b1, `A_CLK_CTRL, 32'((c << 4) | (c % 4)));
      `CHK(main_osc_freq_code, exp_code(c))
      `WAIT(active_src === 2'(c % 4))
      `CHK(active_src, 2'(c % 4))
    end
    apb(1'b1, `A_CLK_CTRL, 32'h00000100);
    `WAIT(active_src === 2'h0)
    $display("end of test clock sources");
    m = $urandom_range(6, 2);
    p = $urandom_range(3, 0);
    apb(1'b1, `A_DIV_BASE + 12'h008, 32'(m - 1));
    apb(1'b1, `A_DIV_BASE, 32'h00100001);
    apb(1'b1, `A_PRESCALE, 32'(p));
    @(posedge core_clk) meas <= 1'b1;
    repeat (2000) @(posedge core_clk);
    meas <= 1'b0;
    #1 `CHK(near(hc, dc, 32 * m), 1'b1)
    `CHK(near(hc, fc, 80), 1'b1)
    `CHK(near(hc, cc, 32 * (p + 1)), 1'b1)
    `CHK(main_osc_trim > 8'h80, 1'b1)
    $display("end of test dividers and trim");
    k = $urandom_range(7, 0);
    apb(1'b1, `A_WAKE_MASK, 32'(1 << k));
    for (int d = 0; d < 2; d++) begin
      apb(1'b1, `A_PWR_CTRL, 32'(d));
      @(posedge core_clk) cmd_sleep <= 1'b1;
      `WAIT(power_mode !== 2'h0)
      @(posedge core_clk) cmd_sleep <= 1'b0;
      `CHK(power_mode, d ? 2'h2 : 2'h1)
      @(posedge core_clk) cmd_irq <= ~(8'h01 << k);
      repeat (8) @(posedge core_clk);
      #1 `CHK(power_mode, d ? 2'h2 : 2'h1)
      `CHK(hf_osc_run, d ? 1'b0 : 1'b1)
      @(posedge core_clk) cmd_irq <= 8'h01 << k;
      for (n = 0; power_mode === (d ? 2'h2 : 2'h1) && n < 50; n++) begin
        @(posedge core_clk); #1;
      end
      `CHK(n, 3)
      for (n = 0; power_mode === 2'h3 && n < 100; n++) begin @(posedge core_clk); #1; end
      `CHK(n, d ? WAKE : 0)
      `CHK(power_mode, 2'h0)
      @(posedge core_clk) cmd_irq <= 8'h00;
    end
    @(posedge core_clk);
    supply_ok <= 1'b0;
    cmd_sleep <= 1'b1;
    repeat (10) @(posedge core_clk);
    #1 `CHK(power_mode, 2'h0)
    @(posedge core_clk);
    supply_ok <= 1'b1;
    cmd_sleep <= 1'b0;
    $display("end of test power modes");
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, `A_RESET_CAUSE, 32'h0000000F);
      trigger(r);
      `WAIT(sys_rst_n === 1'b0)
      `WAIT(sys_rst_n === 1'b1)
      apb(1'b0, `A_RESET_CAUSE, 32'h0);
      `CHK(q[3:0], 4'h1 << r)
      apb(1'b0, `A_DOG_CTRL, 32'h0);
      `CHK(q, 32'h0000FFFF)
    end
    $display("end of test reset sources");
    report_and_stop();
  end
endmodule : tb_top
